// >>> crtcv_vtiming.sv
/*
 * Vertical timing, row scan, cursor, start address and retrace interrupt logic.
 * Assumes line_start and char_tick pulses, vblank and the line compare hit come
 * from the horizontal and blanking logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] Vertical total is 11 bits, equal to scan lines per frame minus two.
// [RULE2] Overflow register holds bits 8 and 9 of the vertical fields.
// [RULE3] Byte panning bits 6-5 are added to the display address.
// [RULE4] Line compare with panning compatibility forces panning to zero until vsync.
// [RULE5] Preset row scan sets the first row scan after retrace, top screen only.
// [RULE6] Row scan advances per line, clears at cell height, else wraps at 1Fh.
// [RULE7] Scan double halves the row scan clock; sync timing is unchanged.
// [RULE8] Cell height bits 6 and 5 hold bit 9 of compare and blank start.
// [RULE9] Cell height bits 4-0 are scan lines per row minus one.
// [RULE10] Cursor shows only when enabled and in text mode.
// [RULE11] Cursor covers start line through end line; start above end shows none.
// [RULE12] Cursor skew delays the cursor by 0 to 3 character clocks.
// [RULE13] Start address is 20 bits and takes effect after vertical retrace.
// [RULE14] Start address is the byte offset of the first pixel divided by four.
// [RULE15] Cursor character address is twice the offset plus the screen base.
// [RULE16] Retrace start is 11 bits counted in scan lines from line zero.
// [RULE17] Lock bit blocks writes to indices 0-7 except overflow bit 4.
// [RULE18] Interrupt output asserts only while the disable bit is zero.
// [RULE19] Arm bit zero holds the interrupt flip-flop cleared.
// [RULE20] Armed flip-flop sets one line after vblank rises; readable as status.
// [RULE21] Vertical retrace ends when line count low nibble equals the width.
// [RULE22] Display end is displayed scan lines minus one.
// [RULE23] Host writes the seven-bit index first, then accesses the data port.
// [RULE24] Line counter increments per line and wraps to zero at frame end.
module crtcv_vtiming
    import crtcv_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire crtcv_io_s   io_req,
    output logic [7:0]       io_rdata,
    input  wire logic        line_start,
    input  wire logic        char_tick,
    input  wire logic        vblank,
    input  wire logic        line_cmp_hit,
    input  wire logic        pan_compat,
    input  wire logic        graphics_mode,
    input  wire logic        cursor_here,
    input  wire logic [3:0]  start_addr_extension,
    input  wire logic        total_b10,
    input  wire logic        sync_start_b10,
    input  wire logic        active_end_b10,
    output logic [10:0]      line_count,
    output logic [4:0]       row_scan,
    output logic             vsync,
    output logic             display_active,
    output logic [1:0]       byte_pan,
    output logic [21:0]      frame_byte_addr,
    output logic [19:0]      cursor_char_addr,
    output logic             cursor_pixel,
    output logic             vert_irq,
    output logic             irq_status
);

    logic [6:0]  index_q;
    logic [7:0]  vt_low_q, ovf_q, preset_q, cell_q, cur_first_q, cur_last_q;
    logic [7:0]  start_hi_q, start_lo_q, cur_hi_q, cur_lo_q;
    logic [7:0]  sync_lo_q, ctrl_q, act_lo_q;
    logic [10:0] total_w, sync_start_w, active_end_w;
    logic        frame_end_w, row_adv_w, locked_w, wr_data_w;
    logic        half_q, pan_force_q, pend_q, vblank_q, irq_ff_q;
    logic [19:0] start_q;
    logic        cursor_row_w, skew_hit_w;

    // [RULE2] overflow bit placement
    // [RULE1] total assembly
    assign total_w      = {total_b10, ovf_q[OVF_TOTAL_B9], ovf_q[OVF_TOTAL_B8], vt_low_q};
    // [RULE16] retrace start assembly
    assign sync_start_w = {sync_start_b10, ovf_q[OVF_SYNC_B9], ovf_q[OVF_SYNC_B8], sync_lo_q};
    // [RULE22] display end assembly
    assign active_end_w = {active_end_b10, ovf_q[OVF_ACTIVE_B9], ovf_q[OVF_ACTIVE_B8], act_lo_q};

    // Last line of the frame is total plus one, giving total plus two lines.
    assign frame_end_w = line_start && (line_count == 11'(total_w + 11'h001));
    assign wr_data_w   = io_req.wr && io_req.data_sel;
    assign locked_w    = ctrl_q[CTRL_LOCK] && (index_q <= IDX_LAST_PROTECTED);

    // [RULE23] index port
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            index_q <= RST_INDEX;
        end else if (io_req.wr && !io_req.data_sel) begin
            index_q <= io_req.wdata[6:0];
        end
    end
    // Data port writes; the lock leaves only overflow bit 4 of indices 0-7 writable.
    // [RULE17] write lock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vt_low_q    <= RST_REG;
            ovf_q       <= RST_REG;
            preset_q    <= RST_REG;
            cell_q      <= RST_REG;
            cur_first_q <= RST_REG;
            cur_last_q  <= RST_REG;
            start_hi_q  <= RST_REG;
            start_lo_q  <= RST_REG;
            cur_hi_q    <= RST_REG;
            cur_lo_q    <= RST_REG;
            sync_lo_q   <= RST_REG;
            ctrl_q      <= RST_SYNC_CTRL;
            act_lo_q    <= RST_REG;
        end else if (wr_data_w) begin
            unique case (index_q)
                IDX_VERT_TOTAL_LOW:   if (!locked_w) vt_low_q <= io_req.wdata;
                IDX_VERT_OVERFLOW: begin
                    if (!locked_w) begin
                        ovf_q <= io_req.wdata;
                    end else begin
                        ovf_q[OVF_CMP_B8] <= io_req.wdata[OVF_CMP_B8];
                    end
                end
                IDX_PRESET_ROW_SCAN:  preset_q    <= io_req.wdata;
                // [RULE8] compare and blank bits
                IDX_CHAR_CELL_HEIGHT: cell_q      <= io_req.wdata;
                IDX_CURSOR_FIRST:     cur_first_q <= io_req.wdata;
                IDX_CURSOR_LAST:      cur_last_q  <= io_req.wdata;
                IDX_START_HIGH:       start_hi_q  <= io_req.wdata;
                IDX_START_LOW:        start_lo_q  <= io_req.wdata;
                IDX_CURSOR_POS_HIGH:  cur_hi_q    <= io_req.wdata;
                IDX_CURSOR_POS_LOW:   cur_lo_q    <= io_req.wdata;
                IDX_VSYNC_START_LOW:  sync_lo_q   <= io_req.wdata;
                IDX_VSYNC_END_CTRL:   ctrl_q      <= io_req.wdata;
                IDX_VACTIVE_END_LOW:  act_lo_q    <= io_req.wdata;
                default: ;
            endcase
        end
    end
    // Read data is registered; unmapped indices read as zero.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            io_rdata <= RST_REG;
        end else if (io_req.rd && !io_req.data_sel) begin
            io_rdata <= {1'b0, index_q};
        end else if (io_req.rd) begin
            unique case (index_q)
                IDX_VERT_TOTAL_LOW:   io_rdata <= vt_low_q;
                IDX_VERT_OVERFLOW:    io_rdata <= ovf_q;
                IDX_PRESET_ROW_SCAN:  io_rdata <= preset_q;
                IDX_CHAR_CELL_HEIGHT: io_rdata <= cell_q;
                IDX_CURSOR_FIRST:     io_rdata <= cur_first_q;
                IDX_CURSOR_LAST:      io_rdata <= cur_last_q;
                IDX_START_HIGH:       io_rdata <= start_hi_q;
                IDX_START_LOW:        io_rdata <= start_lo_q;
                IDX_CURSOR_POS_HIGH:  io_rdata <= cur_hi_q;
                IDX_CURSOR_POS_LOW:   io_rdata <= cur_lo_q;
                IDX_VSYNC_START_LOW:  io_rdata <= sync_lo_q;
                IDX_VSYNC_END_CTRL:   io_rdata <= ctrl_q;
                IDX_VACTIVE_END_LOW:  io_rdata <= act_lo_q;
                default:              io_rdata <= RST_REG;
            endcase
        end
    end
    // [RULE24] line counter
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            line_count <= 11'h000;
        end else if (frame_end_w) begin
            line_count <= 11'h000;
        end else if (line_start) begin
            line_count <= 11'(line_count + 11'h001);
        end
    end
    // [RULE22] active display window
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            display_active <= 1'b0;
        end else begin
            display_active <= (line_count <= active_end_w);
        end
    end
    // Retrace begins at the start line and ends on the low nibble match.
    // [RULE21] retrace width
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vsync <= 1'b0;
        end else if (line_count == sync_start_w) begin
            vsync <= 1'b1;
        end else if (line_count[3:0] == ctrl_q[3:0]) begin
            vsync <= 1'b0;
        end
    end
    // Scan double: the row counter advances on every second line only.
    // [RULE7] halved row clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            half_q <= 1'b0;
        end else if (frame_end_w || line_cmp_hit) begin
            half_q <= 1'b0;
        end else if (line_start) begin
            half_q <= !half_q;
        end
    end
    assign row_adv_w = line_start && (!cell_q[CELL_SCAN_DBL] || half_q);
    // Row scan: preset at frame start, zero at the split, clear at cell height.
    // [RULE5] preset and split
    // [RULE6] cell wrap
    // [RULE9] cell height field
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            row_scan <= 5'h00;
        end else if (frame_end_w) begin
            row_scan <= preset_q[4:0];
        end else if (line_cmp_hit) begin
            row_scan <= 5'h00;
        end else if (row_adv_w) begin
            if (row_scan == cell_q[4:0] || row_scan == ROW_MAX) begin
                row_scan <= 5'h00;
            end else begin
                row_scan <= 5'(row_scan + 5'h01);
            end
        end
    end
    // Start address is picked up when retrace begins; sets win over the clear.
    // [RULE13] start latch
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            start_q <= 20'h00000;
        end else if (line_count == sync_start_w && !vsync) begin
            start_q <= {start_addr_extension, start_hi_q, start_lo_q};
        end
    end
    // [RULE4] panning force flag
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pan_force_q <= 1'b0;
        end else if (line_cmp_hit && pan_compat) begin
            pan_force_q <= 1'b1;
        end else if (line_count == sync_start_w && !vsync) begin
            pan_force_q <= 1'b0;
        end
    end
    // [RULE3] byte panning
    // [RULE14] byte address scaling
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            byte_pan        <= 2'h0;
            frame_byte_addr <= 22'h000000;
        end else begin
            byte_pan        <= pan_force_q ? 2'h0 : preset_q[SHIFT_PAN_LSB +: 2];
            frame_byte_addr <= 22'({start_q, 2'h0} + {20'h00000, byte_pan});
        end
    end
    // [RULE15] cursor address
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cursor_char_addr <= 20'h00000;
        end else begin
            cursor_char_addr <= 20'({3'h0, cur_hi_q, cur_lo_q, 1'b0} + start_q);
        end
    end
    // [RULE10] cursor enable
    // [RULE11] cursor shape
    assign cursor_row_w = !graphics_mode && !cur_first_q[CUR_DISABLE]
                          && (cur_first_q[4:0] <= row_scan) && (row_scan <= cur_last_q[4:0]);

    crtcv_skew #(
        .DEPTH (3)
    ) u_skew (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .char_tick (char_tick),
        .hit_in    (cursor_here),
        .skew      (cur_last_q[SKEW_LSB +: 2]),
        .hit_out   (skew_hit_w)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cursor_pixel <= 1'b0;
        end else begin
            cursor_pixel <= skew_hit_w && cursor_row_w;
        end
    end
    // Vertical blank rise is noted, then the flop sets on the next line.
    // [RULE20] interrupt set timing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vblank_q <= 1'b0;
            pend_q   <= 1'b0;
        end else begin
            vblank_q <= vblank;
            if (vblank && !vblank_q) begin
                pend_q <= 1'b1;
            end else if (line_start) begin
                pend_q <= 1'b0;
            end
        end
    end
    // The arm bit at zero holds the flop clear, so a retrace then is lost.
    // [RULE19] interrupt clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_ff_q <= 1'b0;
        end else if (!ctrl_q[CTRL_IRQ_ARM]) begin
            irq_ff_q <= 1'b0;
        end else if (line_start && pend_q) begin
            irq_ff_q <= 1'b1;
        end
    end
    // [RULE18] interrupt gating
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vert_irq   <= 1'b0;
            irq_status <= 1'b0;
        end else begin
            vert_irq   <= irq_ff_q && !ctrl_q[CTRL_IRQ_OFF];
            irq_status <= irq_ff_q;
        end
    end

    sequence s_pend_line;
        line_start && pend_q && ctrl_q[CTRL_IRQ_ARM];
    endsequence
    sequence s_irq_shown;
        irq_ff_q ##1 irq_status;
    endsequence
    a_irq_set_seen: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE20]
        s_pend_line |=> s_irq_shown)
        else $error("armed interrupt did not set on the line after blank");
    a_irq_held_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE19]
        !ctrl_q[CTRL_IRQ_ARM] |=> !irq_ff_q ##1 !vert_irq)
        else $error("interrupt flop not held clear while disarmed");
    a_irq_disable: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE18]
        ctrl_q[CTRL_IRQ_OFF] && $stable(ctrl_q) |=> !vert_irq)
        else $error("interrupt output asserted while disabled");
    a_total_wrap: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE24]
        (line_start && line_count == 11'(total_w + 11'h001)) |=> (line_count == 11'h000))
        else $error("line counter did not wrap after total plus one");
    a_lock_total: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE17]
        (wr_data_w && ctrl_q[CTRL_LOCK] && index_q == IDX_VERT_TOTAL_LOW) |=> $stable(vt_low_q))
        else $error("locked vertical total was written");
    a_lock_cmp_bit: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE17]
        (wr_data_w && index_q == IDX_VERT_OVERFLOW)
        |=> (ovf_q[OVF_CMP_B8] == $past(io_req.wdata[OVF_CMP_B8])))
        else $error("overflow compare bit not writable");
    a_pan_forced: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE4]
        (line_cmp_hit && pan_compat) |=> ##1 (byte_pan == 2'h0))
        else $error("byte panning not forced after line compare");
    a_vsync_end: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE21]
        (vsync && line_count != sync_start_w && line_count[3:0] == ctrl_q[3:0]) |=> !vsync)
        else $error("retrace did not end on width match");
    a_row_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
        (row_adv_w && !frame_end_w && !line_cmp_hit && row_scan == cell_q[4:0])
        |=> (row_scan == 5'h00))
        else $error("row scan did not clear at cell height");
    a_dbl_hold: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE7]
        (line_start && cell_q[CELL_SCAN_DBL] && !half_q && !frame_end_w && !line_cmp_hit)
        |=> $stable(row_scan))
        else $error("row scan advanced on a doubled line");
    a_frame_preset: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE5]
        frame_end_w |=> (row_scan == $past(preset_q[4:0])))
        else $error("row scan not preset at frame start");
endmodule

`default_nettype wire

// >>> crtcv_pkg.sv
/*
 * Package for the vertical timing, row scan, cursor and start address block.
 * Holds register indices, field positions, reset values and the bus carrier struct.
 * Assumes an indexed two-port register access from the host on the core clock.
 */
`default_nettype none

package crtcv_pkg;

    // Register indices behind the data port.
    localparam logic [6:0] IDX_VERT_TOTAL_LOW   = 7'h06;
    localparam logic [6:0] IDX_VERT_OVERFLOW    = 7'h07;
    localparam logic [6:0] IDX_PRESET_ROW_SCAN  = 7'h08;
    localparam logic [6:0] IDX_CHAR_CELL_HEIGHT = 7'h09;
    localparam logic [6:0] IDX_CURSOR_FIRST     = 7'h0A;
    localparam logic [6:0] IDX_CURSOR_LAST      = 7'h0B;
    localparam logic [6:0] IDX_START_HIGH       = 7'h0C;
    localparam logic [6:0] IDX_START_LOW        = 7'h0D;
    localparam logic [6:0] IDX_CURSOR_POS_HIGH  = 7'h0E;
    localparam logic [6:0] IDX_CURSOR_POS_LOW   = 7'h0F;
    localparam logic [6:0] IDX_VSYNC_START_LOW  = 7'h10;
    localparam logic [6:0] IDX_VSYNC_END_CTRL   = 7'h11;
    localparam logic [6:0] IDX_VACTIVE_END_LOW  = 7'h12;
    localparam logic [6:0] IDX_LAST_PROTECTED   = 7'h07;

    // Field positions.
    localparam int OVF_TOTAL_B8    = 0;
    localparam int OVF_ACTIVE_B8   = 1;
    localparam int OVF_SYNC_B8     = 2;
    localparam int OVF_CMP_B8      = 4;
    localparam int OVF_TOTAL_B9    = 5;
    localparam int OVF_ACTIVE_B9   = 6;
    localparam int OVF_SYNC_B9     = 7;
    localparam int CELL_SCAN_DBL   = 7;
    localparam int CUR_DISABLE     = 5;
    localparam int CTRL_LOCK       = 7;
    localparam int CTRL_IRQ_OFF    = 5;
    localparam int CTRL_IRQ_ARM    = 4;
    localparam int SHIFT_PAN_LSB   = 5;
    localparam int SKEW_LSB        = 5;

    // Values after reset, and the row scan wrap limit.
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam logic [7:0] RST_SYNC_CTRL = 8'h20;
    localparam logic [6:0] RST_INDEX     = 7'h00;
    localparam logic [4:0] ROW_MAX       = 5'h1F;

    // One host cycle: a read or write to the index port or the data port.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       data_sel;
        logic [7:0] wdata;
    } crtcv_io_s;

endpackage

`default_nettype wire

// >>> crtcv_skew.sv
/*
 * Cursor skew delay: delays the cursor hit strobe by 0 to 3 character clocks.
 * Assumes char_tick is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module crtcv_skew
    import crtcv_pkg::*;
#(
    parameter int DEPTH = 3
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             char_tick,
    input  wire logic             hit_in,
    input  wire logic [1:0]       skew,
    output logic                  hit_out
);

    logic [DEPTH:0] tap_q;

    initial begin
        if (DEPTH < 3) begin
            $error("crtcv_skew needs at least three stages");
        end
    end

    assign tap_q[0] = hit_in;

    // Each stage moves one character clock further right.
    generate
        for (genvar i = 1; i <= DEPTH; i++) begin : g_tap
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    tap_q[i] <= 1'b0;
                end else if (char_tick) begin
                    tap_q[i] <= tap_q[i-1];
                end
            end
        end
    endgenerate

    // Selected tap is registered so the output comes from a flip-flop.
    // [RULE12] skew selection
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hit_out <= 1'b0;
        end else begin
            hit_out <= tap_q[skew];
        end
    end

    a_skew_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE12]
        (skew == 2'h0) |=> (hit_out == $past(hit_in)))
        else $error("zero skew did not pass the hit through");

endmodule

`default_nettype wire

// >>> crtcv_host.sv
/*
 * Host model for the vertical timing block: issues indexed register cycles.
 * Assumes the bench calls its tasks one at a time; it drives on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module crtcv_host
    import crtcv_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [7:0] io_rdata,
    output var  crtcv_io_s  io_req
);
    initial io_req = '0;

    // One host cycle, held for a whole clock so the rising edge takes it.
    task automatic cyc(input logic w, input logic r, input logic s, input logic [7:0] d);
        @(negedge core_clk);
        io_req <= '{wr: w, rd: r, data_sel: s, wdata: d};
    endtask

    task automatic wr_reg(input logic [6:0] idx, input logic [7:0] val);
        cyc(1'b1, 1'b0, 1'b0, {1'b0, idx});
        cyc(1'b1, 1'b0, 1'b1, val);
        cyc(1'b0, 1'b0, 1'b0, ~val); // Released data bus does not keep the last value.
    endtask

    // index first, then read the chosen port.
    task automatic rd_reg(input logic [6:0] idx, input logic s, output logic [7:0] val);
        cyc(1'b1, 1'b0, 1'b0, {1'b0, idx});
        cyc(1'b0, 1'b1, s, 8'hFF);
        cyc(1'b0, 1'b0, 1'b0, 8'h00);
        @(negedge core_clk);
        val = io_rdata;
    endtask
endmodule

`default_nettype wire

// >>> crtcv_vtiming_tb_top.sv
/*
 * Testbench for the vertical timing block: registers, counters, retrace, irq, cursor.
 * Assumes the package, the design and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module crtcv_vtiming_tb_top
    import crtcv_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        line_start = 1'b0;
    logic        char_tick = 1'b0;
    logic        vblank = 1'b0;
    logic        line_cmp_hit = 1'b0;
    logic        pan_compat = 1'b0;
    logic        graphics_mode = 1'b0;
    logic        cursor_here = 1'b1;
    crtcv_io_s   io_req;
    logic [7:0]  io_rdata;
    logic [10:0] line_count;
    logic [4:0]  row_scan;
    logic        vsync, display_active, cursor_pixel, vert_irq, irq_status;
    logic [1:0]  byte_pan;
    logic [21:0] frame_byte_addr;
    logic [19:0] cursor_char_addr;
    int          error_cnt = 0;
    int          n_tests = 0;
    logic [15:0] prog [13] = '{16'h060A, 16'h0700, 16'h0903, 16'h0A00, 16'h0B1F, 16'h0C12,
                               16'h0D34, 16'h0E01, 16'h0F00, 16'h1005, 16'h1203, 16'h1198,
                               16'h0840};

    crtcv_host host (.core_clk(core_clk), .io_rdata(io_rdata), .io_req(io_req));

    crtcv_vtiming dut (.core_clk(core_clk), .sys_rst(sys_rst), .io_req(io_req),
        .io_rdata(io_rdata), .line_start(line_start), .char_tick(char_tick),
        .vblank(vblank), .line_cmp_hit(line_cmp_hit), .pan_compat(pan_compat),
        .graphics_mode(graphics_mode), .cursor_here(cursor_here),
        .start_addr_extension(4'hA), .total_b10(1'b0), .sync_start_b10(1'b0),
        .active_end_b10(1'b0), .line_count(line_count), .row_scan(row_scan),
        .vsync(vsync), .display_active(display_active), .byte_pan(byte_pan),
        .frame_byte_addr(frame_byte_addr), .cursor_char_addr(cursor_char_addr),
        .cursor_pixel(cursor_pixel), .vert_irq(vert_irq), .irq_status(irq_status));

    // Clock and a character tick every second cycle.
    initial forever #25 core_clk = ~core_clk;
    always @(negedge core_clk) char_tick <= ~char_tick;

    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Scan lines four cycles apart, optionally with a line compare hit.
    task automatic lines(input int n, input logic hit = 1'b0);
        repeat (n) begin
            @(negedge core_clk);
            line_start <= 1'b1;
            line_cmp_hit <= hit;
            @(negedge core_clk);
            line_start <= 1'b0;
            line_cmp_hit <= 1'b0;
            repeat (2) @(negedge core_clk);
        end
    endtask

    // Bounded walk to a given scan line; running out ends the run.
    task automatic goto(input logic [10:0] n);
        for (int i = 0; i < 40 && line_count !== n; i++) lines(1);
        if (line_count !== n) begin
            error_cnt++;
            final_report();
        end
    endtask

    initial begin
        logic [7:0] v;
        repeat (3) @(negedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 6; i <= 19; i++) begin
            host.rd_reg(7'(i), 1'b1, v);
            chk(v, (i == 17) ? 8'h20 : 8'h00);
        end
        for (int i = 6; i <= 18; i++) begin
            host.wr_reg(7'(i), 8'(8'h40 + i));
            host.rd_reg(7'(i), 1'b1, v);
            chk(v, 8'(8'h40 + i));
        end
        host.rd_reg(7'h0B, 1'b0, v);
        chk(v, 8'h0B);
        foreach (prog[i]) host.wr_reg(prog[i][14:8], prog[i][7:0]);
        host.wr_reg(7'h06, 8'hFF);
        host.rd_reg(7'h06, 1'b1, v);
        chk(v, 8'h0A);
        host.wr_reg(7'h07, 8'hFF);
        host.rd_reg(7'h07, 1'b1, v);
        chk(v, 8'h10);
        host.rd_reg(7'h08, 1'b1, v);
        chk(v, 8'h40);
        host.wr_reg(7'h11, 8'h18);
        host.wr_reg(7'h07, 8'h00);
        $display("registers done");
        goto(3);
        chk(display_active, 1'b1);
        chk(row_scan, 5'h03);
        lines(1);
        chk(display_active, 1'b0);
        chk(row_scan, 5'h00);
        chk(vsync, 1'b0);
        lines(1);
        chk(vsync, 1'b1);
        chk(frame_byte_addr, {4'hA, 16'h1234, 2'b00} + 22'h2);
        chk(cursor_char_addr, 20'h00200 + 20'hA1234);
        goto(7);
        chk(vsync, 1'b1);
        lines(1);
        chk(vsync, 1'b0);
        vblank <= 1'b1;
        lines(1);
        chk({vert_irq, irq_status}, 2'b11);
        vblank <= 1'b0;
        host.wr_reg(7'h11, 8'h08);
        repeat (2) @(negedge core_clk);
        chk({vert_irq, irq_status}, 2'b00);
        vblank <= 1'b1;
        lines(1);
        chk(irq_status, 1'b0);
        vblank <= 1'b0;
        host.wr_reg(7'h11, 8'h38);
        vblank <= 1'b1;
        lines(1);
        chk({vert_irq, irq_status}, 2'b01);
        vblank <= 1'b0;
        goto(11);
        lines(1);
        chk(line_count, 11'h000);
        $display("frame timing done");
        pan_compat <= 1'b1;
        lines(1, 1'b1);
        chk(byte_pan, 2'b00);
        goto(5);
        chk(byte_pan, 2'b10);
        pan_compat <= 1'b0;
        repeat (6) @(negedge core_clk);
        chk(cursor_pixel, 1'b1);
        graphics_mode <= 1'b1;
        repeat (6) @(negedge core_clk);
        chk(cursor_pixel, 1'b0);
        graphics_mode <= 1'b0;
        host.wr_reg(7'h0A, 8'h20);
        repeat (6) @(negedge core_clk);
        chk(cursor_pixel, 1'b0);
        host.wr_reg(7'h0A, 8'h05);
        host.wr_reg(7'h0B, 8'h04);
        repeat (6) @(negedge core_clk);
        chk(cursor_pixel, 1'b0);
        host.wr_reg(7'h0A, 8'h00);
        host.wr_reg(7'h0B, 8'h5F);
        cursor_here <= 1'b0;
        repeat (12) @(negedge core_clk);
        chk(cursor_pixel, 1'b0);
        cursor_here <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk(cursor_pixel, 1'b0);
        repeat (6) @(negedge core_clk);
        chk(cursor_pixel, 1'b1);
        $display("panning and cursor done");
        host.wr_reg(7'h09, 8'h83);
        host.wr_reg(7'h08, 8'h42);
        goto(11);
        lines(1);
        chk(row_scan, 5'h02);
        lines(1);
        chk(row_scan, 5'h02);
        lines(1);
        chk(row_scan, 5'h03);
        $display("scan double done");
        final_report();
    end
endmodule

`default_nettype wire
